// ==== eeprom_quadrant_write_protect.sv ====
/*
 eeprom_quadrant_write_protect: two-wire slave front end that decodes the
 quadrant protect, clear and query control bytes and guards normal writes.
 assumes: the link side runs on the bus clock scl_clk (sampled scl rising
 edge for data, start and stop are seen as sda edges while scl is high and
 arrive as pre-decoded pulses start_det and stop_det in scl_clk domain);
 the flags are held in nonvolatile cells outside, restored on nv_flags and
 written back through nv_write_req / nv_write_done in the sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module eeprom_quadrant_write_protect
(
   // system side
   input wire logic sys_clk,
   input wire logic rst_n,
   // nonvolatile flag cells
   input wire logic [3:0] nv_flags,
   input wire logic nv_valid,
   output logic nv_write_req,
   output logic [3:0] nv_write_flags,
   input wire logic nv_write_done,
   // status
   output logic [3:0] quad_protected,
   output logic write_busy,
   output logic mem_write_go,
   // link side
   input wire logic scl_clk,
   input wire logic start_det,
   input wire logic stop_det,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // strap pins
   input wire logic high_voltage_level,
   input wire logic strap_addr_bit1,
   input wire logic strap_addr_bit2,
   input wire logic half_select_page
);
   // link domain
   quad_protect_pkg::link_state_t state;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic ack_phase;
   logic ack_val;
   logic is_query;
   logic is_mem;
   logic deny;
   logic [1:0] quad_sel;
   logic hv_seen;
   logic mem_byte;
   logic [3:0] flags_l_meta;
   logic [3:0] flags_l;
   logic busy_l_meta;
   logic busy_l;
   logic hv_l;
   logic page_l;
   logic req_tgl;
   logic [2:0] req_op;
   logic [1:0] req_quad;
   logic mem_tgl;
   logic [7:0] next_shift;
   logic [1:0] quad_of_id;
   logic id_valid;
   logic byte_done;
   // system domain
   logic [2:0] req_sync;
   logic [2:0] mem_sync;
   logic [3:0] flags;
   logic loaded;
   logic [2:0] op_s;
   logic [1:0] quad_s;
   logic [3:0] next_flags;
   logic commit;

   assign next_shift = {shift[6:0], sda_in};
   assign byte_done = (bit_cnt == quad_protect_pkg::bit_last);

   // quadrant id to flag index
   always_comb
   begin
      quad_of_id = 2'h0;
      id_valid = 1'b1;
      case (next_shift[3:1])
         quad_protect_pkg::quad_id_0: quad_of_id = 2'h0;
         quad_protect_pkg::quad_id_1: quad_of_id = 2'h1;
         quad_protect_pkg::quad_id_2: quad_of_id = 2'h2;
         quad_protect_pkg::quad_id_3: quad_of_id = 2'h3;
         default: id_valid = 1'b0;
      endcase
   end

   // strap level crossing into the link domain
   sync_level u_hv_sync
   (
      .clk(scl_clk),
      .rst_n(rst_n),
      .d(high_voltage_level),
      .q(hv_l)
   );

   // page select pin crossing into the link domain
   sync_level u_page_sync
   (
      .clk(scl_clk),
      .rst_n(rst_n),
      .d(half_select_page),
      .q(page_l)
   );

   // flag and busy status into the link domain
   always_ff @(posedge scl_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags_l_meta <= quad_protect_pkg::flags_clear;
         flags_l <= quad_protect_pkg::flags_clear;
         busy_l_meta <= 1'b0;
         busy_l <= 1'b0;
      end
      else
      begin
         flags_l_meta <= flags;
         flags_l <= flags_l_meta;
         busy_l_meta <= write_busy;
         busy_l <= busy_l_meta;
      end
   end

   // byte and acknowledge sequencing
   always_ff @(posedge scl_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= quad_protect_pkg::st_idle;
         bit_cnt <= quad_protect_pkg::bit_first;
         shift <= 8'h00;
         ack_phase <= 1'b0;
         ack_val <= 1'b0;
         is_query <= 1'b0;
         is_mem <= 1'b0;
         deny <= 1'b0;
         quad_sel <= 2'h0;
         hv_seen <= 1'b0;
         mem_byte <= 1'b0;
         req_tgl <= 1'b0;
         req_op <= quad_protect_pkg::op_none;
         req_quad <= 2'h0;
         mem_tgl <= 1'b0;
      end
      else if (start_det)
      begin
         state <= busy_l ? quad_protect_pkg::st_skip : quad_protect_pkg::st_ctrl;
         bit_cnt <= quad_protect_pkg::bit_first;
         ack_phase <= 1'b0;
         ack_val <= 1'b0;
         hv_seen <= hv_l;
         mem_byte <= 1'b0;
      end
      else if (stop_det)
      begin
         state <= quad_protect_pkg::st_idle;
         ack_phase <= 1'b0;
         ack_val <= 1'b0;
         // accepted set or clear commits only if the qualifier held throughout
         if (state == quad_protect_pkg::st_cmd && !is_query && !deny && hv_seen && hv_l)
         begin
            req_op <= (quad_sel == 2'h0 && is_mem) ? quad_protect_pkg::op_clear : req_op;
            req_tgl <= ~req_tgl;
         end
         if (state == quad_protect_pkg::st_mem && mem_byte && !deny)
            mem_tgl <= ~mem_tgl;
      end
      else if (state != quad_protect_pkg::st_idle && state != quad_protect_pkg::st_skip)
      begin
         hv_seen <= hv_seen & hv_l;
         if (ack_phase)
         begin
            ack_phase <= 1'b0;
            ack_val <= 1'b0;
         end
         else
         begin
            shift <= next_shift;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done)
            begin
               ack_phase <= 1'b1;
               if (state == quad_protect_pkg::st_ctrl)
               begin
                  // strap bits one and two play no part in decoding
                  is_mem <= 1'b0;
                  if (next_shift[7:4] == quad_protect_pkg::type_code
                      && next_shift[3:1] == quad_protect_pkg::clear_id && !next_shift[0])
                  begin
                     state <= quad_protect_pkg::st_cmd;
                     is_query <= 1'b0;
                     is_mem <= 1'b1;
                     quad_sel <= 2'h0;
                     req_op <= quad_protect_pkg::op_clear;
                     deny <= !hv_l;
                     ack_val <= hv_l;
                  end
                  else if (next_shift[7:4] == quad_protect_pkg::type_code && id_valid)
                  begin
                     state <= quad_protect_pkg::st_cmd;
                     quad_sel <= quad_of_id;
                     req_quad <= quad_of_id;
                     req_op <= quad_protect_pkg::op_set;
                     is_query <= next_shift[0];
                     if (next_shift[0])
                     begin
                        deny <= 1'b0;
                        ack_val <= !flags_l[quad_of_id];
                     end
                     else
                     begin
                        deny <= flags_l[quad_of_id] || !hv_l;
                        ack_val <= !flags_l[quad_of_id] && hv_l;
                     end
                  end
                  else if (!next_shift[0])
                  begin
                     state <= quad_protect_pkg::st_mem;
                     ack_val <= 1'b1;
                  end
                  else
                     state <= quad_protect_pkg::st_skip;
               end
               else if (state == quad_protect_pkg::st_cmd)
                  ack_val <= !is_query && !deny;
               else
               begin
                  // first byte is the word address, later ones are data
                  if (!mem_byte)
                  begin
                     quad_sel <= {page_l, next_shift[7]};
                     ack_val <= 1'b1;
                     deny <= 1'b0;
                  end
                  else
                  begin
                     deny <= deny | flags_l[quad_sel];
                     ack_val <= !flags_l[quad_sel];
                  end
                  mem_byte <= 1'b1;
               end
            end
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = ack_phase & ack_val;

   // link events into the system domain
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_sync <= 3'h0;
         mem_sync <= 3'h0;
      end
      else
      begin
         req_sync <= {req_sync[1:0], req_tgl};
         mem_sync <= {mem_sync[1:0], mem_tgl};
      end
   end

   // op and quadrant are stable long before the toggle lands
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_s <= quad_protect_pkg::op_none;
         quad_s <= 2'h0;
         commit <= 1'b0;
      end
      else
      begin
         // commit follows the capture so the update uses the captured copy
         commit <= (req_sync[2] != req_sync[1]);
         if (req_sync[2] != req_sync[1])
         begin
            op_s <= req_op;
            quad_s <= req_quad;
         end
      end
   end

   always_comb
   begin
      next_flags = flags;
      if (op_s == quad_protect_pkg::op_clear)
         next_flags = quad_protect_pkg::flags_clear;
      else
         next_flags[quad_s] = 1'b1;
   end

   // flag store mirrored from and written to the nonvolatile cells
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flags <= quad_protect_pkg::flags_clear;
         loaded <= 1'b0;
         nv_write_req <= 1'b0;
         nv_write_flags <= quad_protect_pkg::flags_clear;
         write_busy <= 1'b0;
         mem_write_go <= 1'b0;
      end
      else
      begin
         mem_write_go <= (mem_sync[2] != mem_sync[1]) && !write_busy;
         if (!loaded && nv_valid)
         begin
            flags <= nv_flags;
            loaded <= 1'b1;
         end
         else if (commit && !write_busy)
         begin
            nv_write_req <= 1'b1;
            nv_write_flags <= next_flags;
            write_busy <= 1'b1;
         end
         else if (nv_write_done && write_busy)
         begin
            flags <= nv_write_flags;
            nv_write_req <= 1'b0;
            write_busy <= 1'b0;
         end
      end
   end

   assign quad_protected = flags;
endmodule : eeprom_quadrant_write_protect
`default_nettype wire

// ==== quad_protect_pkg.sv ====
/*
 quad_protect_pkg: constants for the quadrant write-protect block.
 assumes: used as quad_protect_pkg::name, never imported.
*/
package quad_protect_pkg;
   localparam logic [3:0] type_code = 4'h6;
   localparam logic [2:0] quad_id_0 = 3'h1;
   localparam logic [2:0] quad_id_1 = 3'h4;
   localparam logic [2:0] quad_id_2 = 3'h5;
   localparam logic [2:0] quad_id_3 = 3'h0;
   localparam logic [2:0] clear_id = 3'h3;
   localparam logic [3:0] flags_clear = 4'h0;
   localparam logic [2:0] bit_last = 3'h7;
   localparam logic [2:0] bit_first = 3'h0;
   localparam int word_bits = 8;
   localparam int quad_count = 4;
   typedef enum logic [4:0]
   {
      st_idle = 5'b0_0001,
      st_ctrl = 5'b0_0010,
      st_cmd = 5'b0_0100,
      st_mem = 5'b0_1000,
      st_skip = 5'b1_0000
   } link_state_t;
   typedef enum logic [2:0]
   {
      op_none = 3'b001,
      op_set = 3'b010,
      op_clear = 3'b100
   } op_t;
endpackage : quad_protect_pkg

// ==== qwp_props.sv ====
/*
 qwp_props: concurrent checks on the quadrant write-protect block.
 assumes: bound to eeprom_quadrant_write_protect; sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module qwp_props
(
   // clocks and reset
   input wire logic sys_clk,
   input wire logic scl_clk,
   input wire logic rst_n,
   // flag cells and status
   input wire logic nv_write_req,
   input wire logic [3:0] nv_write_flags,
   input wire logic nv_write_done,
   input wire logic [3:0] quad_protected,
   input wire logic write_busy,
   input wire logic mem_write_go,
   // link and strap
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic high_voltage_level
);
   sequence s_busy_soon;
      ##[0:2] write_busy;
   endsequence
   property p_req_hold;
      @(posedge sys_clk) disable iff (!rst_n) nv_write_req && !nv_write_done |=> nv_write_req;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("write request dropped early");
   property p_flags_step;
      @(posedge sys_clk) disable iff (!rst_n) $rose(nv_write_req) |-> nv_write_flags == 4'h0 ||
         ($countones(nv_write_flags ^ quad_protected) == 1 && (nv_write_flags & quad_protected) == quad_protected);
   endproperty
   a_flags_step: assert property (p_flags_step) else $error("bad flag update");
   property p_busy_soon;
      @(posedge sys_clk) disable iff (!rst_n) $rose(nv_write_req) |-> s_busy_soon;
   endproperty
   a_busy_soon: assert property (p_busy_soon) else $error("no busy after commit");
   property p_hv_qual;
      @(posedge sys_clk) disable iff (!rst_n) $rose(nv_write_req) |-> $past(high_voltage_level, 4);
   endproperty
   a_hv_qual: assert property (p_hv_qual) else $error("commit without qualifier");
   property p_go_pulse;
      @(posedge sys_clk) disable iff (!rst_n) mem_write_go |=> !mem_write_go;
   endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("write go too long");
   property p_sda_low;
      @(posedge sys_clk) disable iff (!rst_n) sda_out == 1'b0;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("sda driven high");
   property p_ack_slot;
      @(posedge scl_clk) disable iff (!rst_n) sda_oe |=> !sda_oe;
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("ack longer than a slot");
   property p_qp_hold;
      @(posedge sys_clk) disable iff (!rst_n) nv_write_req && !nv_write_done |=> $stable(quad_protected);
   endproperty
   a_qp_hold: assert property (p_qp_hold) else $error("flags moved early");
   property p_one_write;
      @(posedge sys_clk) disable iff (!rst_n) $rose(nv_write_req) |-> !$past(write_busy);
   endproperty
   a_one_write: assert property (p_one_write) else $error("write started while busy");
   property p_flags_land;
      @(posedge sys_clk) disable iff (!rst_n) nv_write_req && nv_write_done |=> quad_protected == $past(nv_write_flags);
   endproperty
   a_flags_land: assert property (p_flags_land) else $error("flags not updated after write");
endmodule : qwp_props
`default_nettype wire

// ==== sync_level.sv ====
/*
 sync_level: two flip-flop synchroniser for one level.
 assumes: d is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module sync_level
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level
   input wire logic d,
   output logic q
);
   logic meta;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sync_level
`default_nettype wire

// ==== testbench.sv ====
/*
 testbench: random and corner protect, clear, query and write frames.
 assumes: flag cells modelled here, finishing a write one cycle on.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic sys_clk, rst_n, nv_valid, nv_write_done, high_voltage_level;
   logic strap_addr_bit1, strap_addr_bit2, half_select_page, nv_write_req, write_busy, mem_write_go;
   logic scl_clk, start_det, stop_det, sda_in, sda_out, sda_oe;
   logic [3:0] nv_flags, nv_write_flags, quad_protected, exp_q;
   logic [2:0] acks;
   int bad_count, n_tests, wr_count, go_count;
   eeprom_quadrant_write_protect u_dut (.sys_clk, .rst_n, .nv_flags, .nv_valid, .nv_write_req, .nv_write_flags,
      .nv_write_done, .quad_protected, .write_busy, .mem_write_go, .scl_clk, .start_det, .stop_det, .sda_in,
      .sda_out, .sda_oe, .high_voltage_level, .strap_addr_bit1, .strap_addr_bit2, .half_select_page);
   twi_master u_master (.scl_clk, .start_det, .stop_det, .sda_in, .sda_oe);
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      nv_write_done <= nv_write_req & ~nv_write_done;
      if (nv_write_req & ~nv_write_done)
      begin
         nv_flags <= nv_write_flags;
         wr_count++;
      end
      if (mem_write_go)
         go_count++;
   end
   function automatic logic [2:0] qid(input int q);
      logic [2:0] t [4] = '{3'h1, 3'h4, 3'h5, 3'h0};
      return t[q];
   endfunction : qid
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] want);
      n_tests++;
      if (seen !== want)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic do_reset();
      rst_n = 1'b0;
      nv_valid = 1'b0;
      fork
         u_master.idle(2);
      join_none
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      nv_valid = 1'b1;
      wait fork;
      u_master.idle(2);
   endtask : do_reset
   task automatic cmd(input logic [7:0] ctrl, input logic [7:0] addr, input logic hv, input logic [2:0] want);
      int n;
      logic exp_wr;
      logic exp_go;
      @(negedge sys_clk);
      high_voltage_level = hv;
      strap_addr_bit1 = 1'($urandom);
      strap_addr_bit2 = 1'($urandom);
      wr_count = 0;
      go_count = 0;
      // qualifier needs two link edges to pass its synchroniser before start
      u_master.idle(2);
      u_master.frame(ctrl, addr, acks);
      check("acks", {1'b0, acks}, {1'b0, want});
      n = 0;
      repeat (12) @(negedge sys_clk);
      while (write_busy !== 1'b0 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 2000)
      begin
         bad_count++;
         end_of_test();
      end
      exp_wr = (ctrl[7:4] == quad_protect_pkg::type_code && !ctrl[0] && want == 3'b111);
      exp_go = (ctrl[7:4] != quad_protect_pkg::type_code && !ctrl[0] && want[0]);
      check("write cycles", 4'(wr_count), {3'b000, exp_wr});
      check("write go", 4'(go_count), {3'b000, exp_go});
      high_voltage_level = 1'b0;
      u_master.idle(2);
   endtask : cmd
   initial
   begin
      int q;
      logic hv;
      logic [7:0] a;
      {nv_write_done, high_voltage_level, strap_addr_bit1, strap_addr_bit2, half_select_page} = '0;
      nv_flags = 4'h0;
      exp_q = 4'h0;
      bad_count = 0;
      n_tests = 0;
      void'($urandom(32'hf661));
      do_reset();
      check("reset", quad_protected, exp_q);
      for (q = 0; q < 4; q++)
         cmd({4'h6, qid(q), 1'b1}, 8'($urandom), 1'($urandom), 3'b100);
      cmd(8'h60, 8'($urandom), 1'b1, 3'b111);
      exp_q[3] = 1'b1;
      repeat (6)
      begin
         q = $urandom_range(3);
         hv = ($urandom_range(2) != 0);
         cmd({4'h6, qid(q), 1'b0}, 8'($urandom), hv, (hv & ~exp_q[q]) ? 3'b111 : 3'b000);
         exp_q[q] = exp_q[q] | hv;
         check("flags", quad_protected, exp_q);
      end
      for (q = 0; q < 4; q++)
         cmd({4'h6, qid(q), 1'b1}, 8'($urandom), 1'($urandom), {~exp_q[q], 2'b00});
      half_select_page = 1'b1;
      cmd(8'hA0, 8'h80 | 8'($urandom), 1'b0, 3'b110);
      half_select_page = 1'($urandom);
      a = 8'($urandom);
      cmd(8'hA0, a, 1'b0, {2'b11, ~exp_q[{half_select_page, a[7]}]});
      do_reset();
      check("kept", quad_protected, exp_q);
      cmd(8'h66, 8'($urandom), 1'b1, 3'b111);
      check("clear", quad_protected, 4'h0);
      cmd(8'hA0, 8'($urandom), 1'b0, 3'b111);
      end_of_test();
   end
endmodule : testbench
bind eeprom_quadrant_write_protect qwp_props u_props (.sys_clk, .scl_clk, .rst_n, .nv_write_req, .nv_write_flags,
   .nv_write_done, .quad_protected, .write_busy, .mem_write_go, .sda_out, .sda_oe, .high_voltage_level);
`default_nettype wire

// ==== twi_master.sv ====
/*
 twi_master: two-wire bus master model for the link side.
 assumes: scl stands low outside frames; sda has a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module twi_master
(
   // link
   output logic scl_clk,
   output logic start_det,
   output logic stop_det,
   output logic sda_in,
   input wire logic sda_oe
);
   logic sda_drv;
   // pulled-up wire seen by the device
   assign sda_in = sda_drv & ~sda_oe;
   initial
   begin
      scl_clk = 1'b0;
      start_det = 1'b0;
      stop_det = 1'b0;
      sda_drv = 1'b1;
   end
   task automatic idle(input int n);
      repeat (n)
      begin
         #32 scl_clk = 1'b1;
         #32 scl_clk = 1'b0;
      end
   endtask : idle
   // msb first, then the ack slot with sda released
   task automatic put_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_drv = b[i];
         idle(1);
      end
      sda_drv = 1'b1;
      #31 ack = sda_oe;
      #1 scl_clk = 1'b1;
      #32 scl_clk = 1'b0;
   endtask : put_byte
   task automatic frame(input logic [7:0] ctrl, input logic [7:0] addr, output logic [2:0] acks);
      start_det = 1'b1;
      idle(1);
      start_det = 1'b0;
      put_byte(ctrl, acks[2]);
      put_byte(addr, acks[1]);
      put_byte(8'($urandom), acks[0]);
      stop_det = 1'b1;
      idle(1);
      stop_det = 1'b0;
   endtask : frame
endmodule : twi_master
`default_nettype wire
